/* File: tmzp_pkg.sv */
package tmzp_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [3:0] OFS_CTL_A      = 4'h0;
  localparam logic [3:0] OFS_CTL_B      = 4'h1;
  localparam logic [3:0] OFS_COUNT_LOW  = 4'h2;
  localparam logic [3:0] OFS_COUNT_HIGH = 4'h3;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_CLEAR  = 4'h5;
  localparam logic [3:0] OFS_IRQ_ENABLE = 4'h6;

  // ************************************************************
  // Field positions of timer_ctl_a
  // ************************************************************
  localparam int CTLA_ENABLE_BIT = 7;
  localparam int CTLA_OUT_BIT    = 5;
  localparam int CTLA_MODE16_BIT = 4;
  localparam int CTLA_POST_LSB   = 0;
  localparam int SEL_W           = 4;

  // ************************************************************
  // Field positions of timer_ctl_b
  // ************************************************************
  localparam int CTLB_EXTCLK_BIT = 5;
  localparam int CTLB_ASYNC_BIT  = 4;
  localparam int CTLB_PRE_LSB    = 0;

  // ************************************************************
  // Interrupt status layout
  // ************************************************************
  localparam int IRQ_W         = 2;
  localparam int IRQ_FLAG_BIT  = 0;
  localparam int IRQ_EVENT_BIT = 1;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_CTL_A      = 8'h00;
  localparam logic [7:0] RST_CTL_B      = 8'h00;
  localparam logic [7:0] RST_COUNT_LOW  = 8'h00;
  localparam logic [7:0] RST_COUNT_HIGH = 8'hff;
  localparam logic [1:0] RST_IRQ        = 2'h0;

  // ************************************************************
  // Prescaler depth: sixteen ratios, largest 1:32768
  // ************************************************************
  localparam int PRE_W = 15;

endpackage

/* File: tmzp_prescale.sv */
`timescale 1ns/1ns
module tmzp_prescale #(
  parameter int CNT_W = tmzp_pkg::PRE_W,
  parameter int SEL_W = tmzp_pkg::SEL_W
) (
  input  wire logic             mclk,     // System clock
  input  wire logic             nrst,     // Async reset, active low
  input  wire logic             clear,    // Synchronous clear of the count
  input  wire logic             in_tick,  // Input clock event
  input  wire logic [SEL_W-1:0] sel,      // Ratio select, 2**sel
  output logic                  out_tick  // One pulse per 2**sel inputs
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] mask;

  // Low sel bits of a free counter all ones marks the last input of a group
  always_comb begin
    mask = CNT_W'((32'h1 << sel) - 32'h1);
  end

  always_comb begin
    out_tick = in_tick && ((cnt & mask) == mask);
  end

  // Count is internal only; no bus path reads or loads it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
    end else if (clear) begin
      cnt <= '0;
    end else if (in_tick) begin
      cnt <= cnt + CNT_W'(1);
    end
  end

endmodule

/* File: tmzp_postscale.sv */
`timescale 1ns/1ns
module tmzp_postscale #(
  parameter int SEL_W = tmzp_pkg::SEL_W
) (
  input  wire logic             mclk,     // System clock
  input  wire logic             nrst,     // Async reset, active low
  input  wire logic             clear,    // Synchronous clear of the count
  input  wire logic             in_event, // Match or rollover event
  input  wire logic [SEL_W-1:0] sel,      // Ratio select, sel+1
  output logic                  out_event // One pulse per sel+1 events
);

  logic [SEL_W-1:0] cnt;

  always_comb begin
    out_event = in_event && (cnt == sel);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
    end else if (clear) begin
      cnt <= '0;
    end else if (out_event) begin
      cnt <= '0;
    end else if (in_event) begin
      cnt <= cnt + SEL_W'(1);
    end
  end

endmodule

/* File: tmzp_timer.sv */
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
// Behaviour
// - The prescaler divides the input clock by 2**prescale_select, from 1:1 to 1:32768.
// - Software can neither read nor load the prescaler count.
// - Writes to count_low_byte, timer_ctl_a, timer_ctl_b and resets clear the prescaler count.
// - The postscaler divides events by 1 to 16 set by postscale_select and its count is hidden.
// - Writes to count_low_byte, timer_ctl_a, timer_ctl_b and resets clear the postscaler count.
// - In sleep a timer running synchronously stops counting.
// - In sleep an asynchronous timer with a live input clock keeps counting and wakes if enabled.
// - In 8-bit mode a match occurs when count_low_byte equals count_high_byte, the period.
// - In 16-bit mode a rollover occurs when full_count wraps from all ones to zero.
// - timer_event_flag sets once per postscale_select plus one events, every event at 1:1.
// - With timer_irq_enable set, a set timer_event_flag interrupts and may wake from sleep.
// - The timer output is offered to the pin selector and as a trigger to other peripherals.
// - Software reads the timer output level through a read-only bit of timer_ctl_a.
// - timer_pulse_out lasts from a postscaled match or wrap until the next prescaled counter tick.
// - The visible output toggles on each rising edge of timer_pulse_out, a 50% square wave.
module tmzp_timer (
  input  wire logic                        mclk,        // System clock, 125 MHz
  input  wire logic                        nrst,        // Async reset, active low
  input  wire logic [tmzp_pkg::ADDR_W-1:0] addr,        // Register address
  input  wire logic [tmzp_pkg::DATA_W-1:0] wr_data,     // Write data
  input  wire logic                        wr_en,       // Write strobe
  input  wire logic                        rd_en,       // Read strobe
  output logic      [tmzp_pkg::DATA_W-1:0] rd_data,     // Read data, cycle after rd_en
  input  wire logic                        ext_clk,     // External count input, synchronous
  input  wire logic                        sleep,       // Device is in sleep
  output logic                             irq,         // Level interrupt
  output logic                             wake,        // Wake request while sleeping
  output logic                             timer_pulse_out, // Internal pulse
  output logic                             timer_out_level, // Toggle output, to pins
  output logic                             adc_trigger  // Trigger to other peripherals
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [7:0]                 timer_ctl_a;
  logic [7:0]                 timer_ctl_b;
  logic [7:0]                 count_low_byte;
  logic [7:0]                 count_high_byte;
  logic [7:0]                 high_shadow;
  logic [7:0]                 high_wr_buf;
  logic [tmzp_pkg::IRQ_W-1:0] irq_status;
  logic [tmzp_pkg::IRQ_W-1:0] irq_enable;

  // ************************************************************
  // Decoded fields
  // ************************************************************
  logic                       enable;
  logic                       mode16;
  logic                       ext_sel;
  logic                       async_mode;
  logic [tmzp_pkg::SEL_W-1:0] prescale_select;
  logic [tmzp_pkg::SEL_W-1:0] postscale_select;

  always_comb begin
    enable           = timer_ctl_a[tmzp_pkg::CTLA_ENABLE_BIT];
    mode16           = timer_ctl_a[tmzp_pkg::CTLA_MODE16_BIT];
    postscale_select = timer_ctl_a[tmzp_pkg::CTLA_POST_LSB +: tmzp_pkg::SEL_W];
    ext_sel          = timer_ctl_b[tmzp_pkg::CTLB_EXTCLK_BIT];
    async_mode       = timer_ctl_b[tmzp_pkg::CTLB_ASYNC_BIT];
    prescale_select  = timer_ctl_b[tmzp_pkg::CTLB_PRE_LSB +: tmzp_pkg::SEL_W];
  end

  // ************************************************************
  // Bus write decode
  // ************************************************************
  logic wr_ctl_a;
  logic wr_ctl_b;
  logic wr_low;
  logic wr_high;
  logic wr_clear;
  logic wr_enable;
  logic scaler_clear;

  always_comb begin
    wr_ctl_a     = wr_en && (addr == tmzp_pkg::OFS_CTL_A);
    wr_ctl_b     = wr_en && (addr == tmzp_pkg::OFS_CTL_B);
    wr_low       = wr_en && (addr == tmzp_pkg::OFS_COUNT_LOW);
    wr_high      = wr_en && (addr == tmzp_pkg::OFS_COUNT_HIGH);
    wr_clear     = wr_en && (addr == tmzp_pkg::OFS_IRQ_CLEAR);
    wr_enable    = wr_en && (addr == tmzp_pkg::OFS_IRQ_ENABLE);
    scaler_clear = wr_low || wr_ctl_a || wr_ctl_b;
  end

  // ************************************************************
  // Input clock selection and sleep gating
  // ************************************************************
  logic ext_clk_d;
  logic src_tick;
  logic run;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ext_clk_d <= 1'b0;
    end else begin
      ext_clk_d <= ext_clk;
    end
  end

  // A synchronous timer halts in sleep; an asynchronous one runs on while
  // its input edges keep coming, so a stopped source simply yields no tick
  always_comb begin
    run      = enable && (!sleep || async_mode);
    src_tick = run && (ext_sel ? (ext_clk && !ext_clk_d) : 1'b1);
  end

  // ************************************************************
  // Prescaler
  // ************************************************************
  logic count_tick;

  tmzp_prescale #(
    .CNT_W (tmzp_pkg::PRE_W),
    .SEL_W (tmzp_pkg::SEL_W)
  ) u_pre (
    .mclk     (mclk),
    .nrst     (nrst),
    .clear    (scaler_clear),
    .in_tick  (src_tick),
    .sel      (prescale_select),
    .out_tick (count_tick)
  );

  // ************************************************************
  // Counter and event detection
  // ************************************************************
  logic        match8;
  logic        wrap16;
  logic        raw_event;
  logic [15:0] full_count;
  logic [15:0] next_full;

  always_comb begin
    full_count = {count_high_byte, count_low_byte};
    next_full  = full_count + 16'h0001;
    match8     = !mode16 && (count_low_byte == count_high_byte);
    wrap16     = mode16 && (full_count == 16'hffff);
    raw_event  = count_tick && (match8 || wrap16);
  end

  // A bus write to the low byte wins over a count in the same cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_low_byte <= tmzp_pkg::RST_COUNT_LOW;
    end else if (wr_low) begin
      count_low_byte <= wr_data;
    end else if (count_tick) begin
      if (match8) begin
        count_low_byte <= 8'h00;
      end else begin
        count_low_byte <= next_full[7:0];
      end
    end
  end

  // In 16-bit mode the high byte is written through a buffer that lands
  // with the low byte write, so software loads both halves at once
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_high_byte <= tmzp_pkg::RST_COUNT_HIGH;
    end else if (wr_high && !mode16) begin
      count_high_byte <= wr_data;
    end else if (wr_low && mode16) begin
      count_high_byte <= high_wr_buf;
    end else if (count_tick && mode16 && !wr_low) begin
      count_high_byte <= next_full[15:8];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      high_wr_buf <= tmzp_pkg::RST_COUNT_HIGH;
    end else if (wr_high) begin
      high_wr_buf <= wr_data;
    end
  end

  // Reading the low byte latches the high byte so a 16-bit read is coherent
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      high_shadow <= tmzp_pkg::RST_COUNT_HIGH;
    end else if (rd_en && (addr == tmzp_pkg::OFS_COUNT_LOW)) begin
      high_shadow <= count_high_byte;
    end
  end

  // ************************************************************
  // Postscaler
  // ************************************************************
  logic post_event;

  tmzp_postscale #(
    .SEL_W (tmzp_pkg::SEL_W)
  ) u_post (
    .mclk      (mclk),
    .nrst      (nrst),
    .clear     (scaler_clear),
    .in_event  (raw_event),
    .sel       (postscale_select),
    .out_event (post_event)
  );

  // ************************************************************
  // Output pulse and toggle
  // ************************************************************
  // Pulse holds from the postscaled event until the next counter tick,
  // which is one period of the clock that advances the counter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timer_pulse_out <= 1'b0;
    end else if (post_event) begin
      timer_pulse_out <= 1'b1;
    end else if (count_tick || !enable) begin
      timer_pulse_out <= 1'b0;
    end
  end

  logic pulse_d;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pulse_d <= 1'b0;
    end else begin
      pulse_d <= timer_pulse_out;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timer_out_level <= 1'b0;
    end else if (timer_pulse_out && !pulse_d) begin
      timer_out_level <= !timer_out_level;
    end
  end

  // Peripheral trigger follows the pulse so a converter sees one start each
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      adc_trigger <= 1'b0;
    end else begin
      adc_trigger <= timer_pulse_out && !pulse_d;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  // The output bit of timer_ctl_a is not stored; reads show the live level
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timer_ctl_a <= tmzp_pkg::RST_CTL_A;
    end else if (wr_ctl_a) begin
      timer_ctl_a <= wr_data & ~(8'h01 << tmzp_pkg::CTLA_OUT_BIT);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timer_ctl_b <= tmzp_pkg::RST_CTL_B;
    end else if (wr_ctl_b) begin
      timer_ctl_b <= wr_data;
    end
  end

  // ************************************************************
  // Interrupt status, enable and outputs
  // ************************************************************
  logic [tmzp_pkg::IRQ_W-1:0] irq_set;
  logic [tmzp_pkg::IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set                          = '0;
    irq_set[tmzp_pkg::IRQ_FLAG_BIT]  = post_event;
    irq_set[tmzp_pkg::IRQ_EVENT_BIT] = raw_event;
    irq_clr                          = wr_clear ? wr_data[tmzp_pkg::IRQ_W-1:0] : '0;
  end

  // A set arriving with a clear wins so no event is lost
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_status <= tmzp_pkg::RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_enable <= tmzp_pkg::RST_IRQ;
    end else if (wr_enable) begin
      irq_enable <= wr_data[tmzp_pkg::IRQ_W-1:0];
    end
  end

  // Outputs lag the status by one cycle to come straight from flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq  <= 1'b0;
      wake <= 1'b0;
    end else begin
      irq  <= |(irq_status & irq_enable);
      wake <= sleep && |(irq_status & irq_enable);
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    unique case (addr)
      tmzp_pkg::OFS_CTL_A: begin
        rd_mux = timer_ctl_a;
        rd_mux[tmzp_pkg::CTLA_OUT_BIT] = timer_out_level;
      end
      tmzp_pkg::OFS_CTL_B: begin
        rd_mux = timer_ctl_b;
      end
      tmzp_pkg::OFS_COUNT_LOW: begin
        rd_mux = count_low_byte;
      end
      tmzp_pkg::OFS_COUNT_HIGH: begin
        rd_mux = mode16 ? high_shadow : count_high_byte;
      end
      tmzp_pkg::OFS_IRQ_STATUS: begin
        rd_mux = 8'(irq_status);
      end
      tmzp_pkg::OFS_IRQ_ENABLE: begin
        rd_mux = 8'(irq_enable);
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // Data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      rd_data <= rd_mux;
    end else begin
      rd_data <= 8'h00;
    end
  end

endmodule

/* File: tmzp_timer_props.sv */
`timescale 1ns/1ns
module tmzp_timer_props (
  input wire logic                        mclk,            // Clock
  input wire logic                        nrst,            // Reset, active low
  input wire logic [tmzp_pkg::ADDR_W-1:0] addr,            // Address
  input wire logic [tmzp_pkg::DATA_W-1:0] wr_data,         // Write data
  input wire logic                        wr_en,           // Write strobe
  input wire logic                        rd_en,           // Read strobe
  input wire logic [tmzp_pkg::DATA_W-1:0] rd_data,         // Read data
  input wire logic                        ext_clk,         // Count input
  input wire logic                        sleep,           // Sleep
  input wire logic                        irq,             // Interrupt
  input wire logic                        wake,            // Wake
  input wire logic                        timer_pulse_out, // Pulse
  input wire logic                        timer_out_level, // Toggle output
  input wire logic                        adc_trigger      // Trigger
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // ************************************************************
  // Output toggle steps
  // ************************************************************
  sequence pulse_rise;
    timer_pulse_out && !$past(timer_pulse_out);
  endsequence
  sequence toggle_step;
    adc_trigger && (timer_out_level != $past(timer_out_level));
  endsequence

  chk_read_idle: assert property (!$past(rd_en) |-> rd_data == '0)
    else $error("read data outside the read answer cycle");
  chk_read_unmapped: assert property (
    rd_en && (addr >= 4'h7 || addr == tmzp_pkg::OFS_IRQ_CLEAR) |=> rd_data == '0)
    else $error("unmapped or clear address read nonzero");
  chk_status_width: assert property (
    rd_en && addr == tmzp_pkg::OFS_IRQ_STATUS |=> rd_data[7:2] == 6'h00)
    else $error("status read has bits above the flags");
  chk_level_readback: assert property (
    rd_en && addr == tmzp_pkg::OFS_CTL_A |=> rd_data[5] == $past(timer_out_level))
    else $error("output level bit differs from output");
  chk_wake_follow: assert property (wake == (irq && $past(sleep)))
    else $error("wake not equal to sleeping interrupt");
  chk_trig_level: assert property (
    adc_trigger == (timer_out_level != $past(timer_out_level)))
    else $error("trigger not in the toggle cycle");
  chk_toggle_after: assert property (pulse_rise |=> toggle_step)
    else $error("pulse rise without toggle next cycle");
  chk_toggle_cause: assert property (
    $changed(timer_out_level) |-> $past(timer_pulse_out) && !$past(timer_pulse_out, 2))
    else $error("toggle without a pulse rise");
endmodule

bind tmzp_timer tmzp_timer_props i_props (
  .mclk(mclk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .ext_clk(ext_clk), .sleep(sleep), .irq(irq),
  .wake(wake), .timer_pulse_out(timer_pulse_out), .timer_out_level(timer_out_level),
  .adc_trigger(adc_trigger)
);

/* File: tmzp_timer_tb.sv */
`timescale 1ns/1ns
module tmzp_timer_tb;
  logic                        mclk      = 1'b0;
  logic                        nrst      = 1'b0;
  logic [tmzp_pkg::ADDR_W-1:0] addr      = '0;
  logic [tmzp_pkg::DATA_W-1:0] wr_data   = '0;
  logic                        wr_en     = 1'b0;
  logic                        rd_en     = 1'b0;
  logic                        ext_clk   = 1'b0;
  logic                        sleep     = 1'b0;
  logic                        pulse_q   = 1'b0;
  logic [tmzp_pkg::DATA_W-1:0] rd_data;
  logic                        irq;
  logic                        wake;
  logic                        timer_pulse_out;
  logic                        timer_out_level;
  logic                        adc_trigger;
  logic [7:0]                  d;
  int                          n_fail    = 0;
  int                          checks    = 0;
  int                          cyc       = 0;
  int                          n_rise    = 0;
  int                          n_trig    = 0;
  int                          last_rise = 0;
  int                          period    = 0;
  int                          n0;
  int                          seed      = 44157;

  always #4 mclk = ~mclk;

  tmzp_timer i_dut (
    .mclk(mclk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .ext_clk(ext_clk), .sleep(sleep), .irq(irq),
    .wake(wake), .timer_pulse_out(timer_pulse_out), .timer_out_level(timer_out_level),
    .adc_trigger(adc_trigger)
  );

  // ************************************************************
  // Monitors: pulse period, external count input, hang guard
  // ************************************************************
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    ext_clk <= (cyc % 6) < 3;
    pulse_q <= timer_pulse_out;
    if (adc_trigger) n_trig <= n_trig + 1;
    if (timer_pulse_out && !pulse_q) begin
      n_rise <= n_rise + 1;
      period <= cyc - last_rise;
      last_rise <= cyc;
    end
  end
  always @(posedge mclk) if (cyc == 90000) begin
    n_fail++;
    final_report;
  end

  // ************************************************************
  // Tasks and expectations
  // ************************************************************
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_count(input int got, input int exp, input string what);
    checks++;
    if (got != exp) begin
      n_fail++;
      $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask
  task automatic wait_rises(input int target, input int limit);
    int k;
    k = 0;
    while (n_rise < target && k < limit) begin
      @(posedge mclk);
      #1 k++;
    end
    check_count(int'(n_rise >= target), 1, "pulse wait");
  endtask
  function automatic int exp_period(int hi, int pre, int post, int ext);
    return (hi + 1) * (1 << pre) * (post + 1) * (ext ? 6 : 1);
  endfunction
  function automatic logic [7:0] exp_rst(int a);
    return (a == tmzp_pkg::OFS_COUNT_HIGH) ? tmzp_pkg::RST_COUNT_HIGH : 8'h00;
  endfunction
  // Stop first so no stale event from the old setting lands in the measurement
  task automatic run_cfg(input int hi, input int pre, input int post, input int ext);
    int ex;
    ex = exp_period(hi, pre, post, ext);
    wr(tmzp_pkg::OFS_CTL_A, 8'h00);
    repeat (4) @(posedge mclk);
    wr(tmzp_pkg::OFS_COUNT_HIGH, hi[7:0]);
    wr(tmzp_pkg::OFS_COUNT_LOW, 8'h00);
    wr(tmzp_pkg::OFS_CTL_B, {2'b00, ext[0], 1'b0, pre[3:0]});
    n0 = n_rise;
    wr(tmzp_pkg::OFS_CTL_A, {4'h8, post[3:0]});
    wait_rises(n0 + 2, 3 * ex + 40);
    check_count(period, ex, "event period");
  endtask
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], d);
      check_byte(d, exp_rst(a), "reset value");
    end
    $display("test reset values done");
    for (int p = 0; p < 16; p++) begin
      wr(tmzp_pkg::OFS_CTL_B, {4'h0, p[3:0]});
      rd(tmzp_pkg::OFS_CTL_B, d);
      check_byte(d, {4'h0, p[3:0]}, "prescale select");
      if (p < 12) run_cfg(1, p, 0, 0);
    end
    $display("test prescaler done");
    for (int p = 0; p < 16; p++) run_cfg(1, 0, p, 0);
    run_cfg(2, 1, 1, 1);
    for (int k = 0; k < 6; k++) run_cfg(1 + ($unsigned($random(seed)) % 15),
      $unsigned($random(seed)) % 3, $unsigned($random(seed)) % 16, 0);
    $display("test postscaler done");
    // Rewrites keep the hidden counts from ever reaching a tick or an output event
    for (int c = 0; c < 6; c++) begin
      if (c < 3) run_cfg(1, 4, 0, 0);
      else run_cfg(0, 0, 15, 0);
      n0 = n_rise;
      repeat (12) begin
        if (c % 3 == 0) wr(tmzp_pkg::OFS_COUNT_LOW, 8'h00);
        else if (c % 3 == 1) wr(tmzp_pkg::OFS_CTL_A, (c < 3) ? 8'h80 : 8'h8f);
        else wr(tmzp_pkg::OFS_CTL_B, (c < 3) ? 8'h04 : 8'h00);
        repeat (8) @(posedge mclk);
      end
      check_count(n_rise, n0, "cleared counts");
    end
    $display("test count clearing done");
    wr(tmzp_pkg::OFS_CTL_A, 8'h10);
    wr(tmzp_pkg::OFS_CTL_B, 8'h00);
    wr(tmzp_pkg::OFS_COUNT_HIGH, 8'hfe);
    wr(tmzp_pkg::OFS_COUNT_LOW, 8'hf0);
    rd(tmzp_pkg::OFS_COUNT_LOW, d);
    check_byte(d, 8'hf0, "low byte");
    rd(tmzp_pkg::OFS_COUNT_HIGH, d);
    check_byte(d, 8'hfe, "high byte");
    n0 = n_rise;
    wr(tmzp_pkg::OFS_CTL_A, 8'h90);
    repeat (200) @(posedge mclk);
    check_count(n_rise, n0, "no early wrap");
    repeat (150) @(posedge mclk);
    wr(tmzp_pkg::OFS_CTL_A, 8'h10);
    check_count(n_rise, n0 + 1, "one wrap");
    rd(tmzp_pkg::OFS_COUNT_LOW, d);
    rd(tmzp_pkg::OFS_COUNT_HIGH, d);
    check_byte(d, 8'h00, "high after wrap");
    $display("test wide mode done");
    wr(tmzp_pkg::OFS_IRQ_CLEAR, 8'h03);
    rd(tmzp_pkg::OFS_IRQ_STATUS, d);
    check_byte(d, 8'h00, "status cleared");
    run_cfg(2, 0, 1, 0);
    wr(tmzp_pkg::OFS_CTL_A, 8'h20);
    rd(tmzp_pkg::OFS_CTL_A, d);
    check_byte(d, {2'b00, n_rise[0], 5'h00}, "level bit");
    check_byte({7'h0, timer_out_level}, {7'h0, n_rise[0]}, "level pin");
    check_count(n_trig, n_rise, "trigger count");
    rd(tmzp_pkg::OFS_IRQ_STATUS, d);
    check_byte({7'h0, d[0]}, 8'h01, "flag set");
    check_byte({7'h0, irq}, 8'h00, "masked irq");
    wr(tmzp_pkg::OFS_IRQ_ENABLE, 8'h01);
    sleep <= 1'b1;
    repeat (2) @(posedge mclk);
    check_byte({6'h0, wake, irq}, 8'h03, "irq and wake");
    wr(tmzp_pkg::OFS_IRQ_CLEAR, 8'h01);
    repeat (2) @(posedge mclk);
    check_byte({6'h0, wake, irq}, 8'h00, "cleared irq");
    $display("test interrupt done");
    wr(tmzp_pkg::OFS_COUNT_HIGH, 8'h02);
    wr(tmzp_pkg::OFS_CTL_A, 8'h80);
    n0 = n_rise;
    repeat (60) @(posedge mclk);
    check_count(n_rise, n0, "sync sleep halt");
    wr(tmzp_pkg::OFS_CTL_B, 8'h10);
    repeat (40) @(posedge mclk);
    check_count(int'(n_rise > n0), 1, "async sleep count");
    check_byte({7'h0, wake}, 8'h01, "async wake");
    sleep <= 1'b0;
    repeat (2) @(posedge mclk);
    check_byte({6'h0, wake, irq}, 8'h01, "awake irq");
    $display("test sleep done");
    final_report;
  end
endmodule
